//--- core/lpp_defs.svh
// Constants for the sleep-mode sequencer and probe pins
`ifndef LPP_DEFS_SVH
`define LPP_DEFS_SVH

`define LPP_CLK_PERIOD_PS 5000
`define LPP_ENTRY_NS 800
`define LPP_EXIT_US 200
// Least times round up to whole cycles
`define LPP_ENTRY_CYC ((`LPP_ENTRY_NS * 1000 + `LPP_CLK_PERIOD_PS - 1) / `LPP_CLK_PERIOD_PS)
`define LPP_EXIT_CYC ((`LPP_EXIT_US * 1000000 + `LPP_CLK_PERIOD_PS - 1) / `LPP_CLK_PERIOD_PS)
`define LPP_CNT_W 16
`define LPP_NODE_W 16
`define LPP_SEL_W 4

`endif

//--- core/lpp_pkg.sv
// Types shared by the sleep-mode sequencer and probe pins
package lpp_pkg;
	typedef enum logic [1:0] {
		LPP_RUN,
		LPP_ENTERING,
		LPP_SLEEP,
		LPP_WAKING
	} lpp_state_t;

	// Probe pin settings
	typedef struct packed {
		logic enable;
		logic [3:0] sel;
	} lpp_probe_cfg_t;

	// Pad drive of one pin
	typedef struct packed {
		logic out;
		logic oe;
	} lpp_pad_t;
endpackage : lpp_pkg

//--- core/lpp_probe_pin.sv
// One probe pin: node selector or plain user I/O
`timescale 1ns/1ps
`include "lpp_defs.svh"
module lpp_probe_pin (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Control
	input wire lpp_pkg::lpp_probe_cfg_t cfg,
	input wire logic probe_allowed,
	input wire logic io_active,
	// Internal nodes and user I/O
	input wire logic [`LPP_NODE_W-1:0] nodes,
	input wire logic user_out,
	input wire logic user_oe,
	// Pad drive
	output lpp_pkg::lpp_pad_t pad
);
	// Probe mode only while probing is still allowed
	wire probing = cfg.enable & probe_allowed;
	wire node_bit = nodes[cfg.sel];
	wire out_d = probing ? node_bit : user_out;
	wire oe_d = io_active & (probing | user_oe);

	// Registered pad drive
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pad <= '0;
		end else begin
			pad.out <= io_active & out_d;
			pad.oe <= oe_d;
		end
	end
endmodule : lpp_probe_pin

//--- core/lpp_sleep_ctrl.sv
// Sleep-mode sequencer with two probe pins
`timescale 1ns/1ps
`include "lpp_defs.svh"
module lpp_sleep_ctrl (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Pin from the outside controller
	input wire logic sleep_request_pin,
	// Probe configuration and permanent lock request
	input wire lpp_pkg::lpp_probe_cfg_t probe_cfg_a,
	input wire lpp_pkg::lpp_probe_cfg_t probe_cfg_b,
	input wire logic probe_lock,
	// Internal nodes and user I/O for probe pins
	input wire logic [`LPP_NODE_W-1:0] nodes,
	input wire logic [1:0] user_out,
	input wire logic [1:0] user_oe,
	// Status and power controls
	output logic core_on,
	output logic io_enable,
	output logic in_buf_on,
	output logic sleeping,
	output logic probe_locked,
	// Probe pads
	output lpp_pkg::lpp_pad_t probe_output_a,
	output lpp_pkg::lpp_pad_t probe_output_b
);
	// Entry and exit delays as whole clock cycles; both fit the counter
	localparam logic [`LPP_CNT_W-1:0] ENTRY_CYC = `LPP_CNT_W'(`LPP_ENTRY_CYC);
	localparam logic [`LPP_CNT_W-1:0] EXIT_CYC = `LPP_CNT_W'(`LPP_EXIT_CYC);

	// Sequencing overview
	//   run       normal operation, pin seen low
	//   entering  pin seen high, entry delay counting, still fully on
	//   sleep     core, input buffers and pads all off
	//   waking    pin seen low, exit delay counting, still fully off
	//
	// The pin passes two flops before the sequencer sees it, so each
	// delay is measured from the synchronised edge. The extra cycles
	// only lengthen both delays, which is the safe direction: the core
	// never stops before the entry delay and never restarts before the
	// exit delay.
	//
	// A request dropped while entering returns to run with nothing shut
	// down, so a glitch on the pin costs no partial power-down.
	// A request raised again while waking goes straight back to sleep;
	// the outputs therefore never come on before a full exit delay of
	// continuously low pin.
	//
	// Limitations
	//   The counter is sized for the exit delay at this clock rate; a
	//   slower clock shortens the counts, a much faster one needs a
	//   wider counter.
	//   The probe lock is held in a flop cleared only by reset; it
	//   stands in for a one-time programmable fuse.

	// Pin synchroniser stages
	logic req_s1_q;
	logic req_s2_q;
	// Sequencer state and delay counter
	lpp_pkg::lpp_state_t state_q;
	lpp_pkg::lpp_state_t state_d;
	logic [`LPP_CNT_W-1:0] cnt_q;
	logic [`LPP_CNT_W-1:0] cnt_d;
	// One-way probe lock
	logic lock_q;

	// True in the states where the device behaves normally
	function automatic logic is_awake(input lpp_pkg::lpp_state_t s);
		return (s == lpp_pkg::LPP_RUN) | (s == lpp_pkg::LPP_ENTERING);
	endfunction : is_awake

	// Two-stage synchroniser for the pin
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
		end else begin
			req_s1_q <= sleep_request_pin;
			req_s2_q <= req_s1_q;
		end
	end

	// Delay end points; the counter is zero on entering either timed state
	wire entry_done = (cnt_q == ENTRY_CYC - `LPP_CNT_W'(1));
	wire exit_done = (cnt_q == EXIT_CYC - `LPP_CNT_W'(1));
	// Counter step; never wraps, the longest delay ends well below the top
	wire [`LPP_CNT_W-1:0] cnt_next = cnt_q + `LPP_CNT_W'(1);

	// Next state
	always_comb begin
		state_d = state_q;
		cnt_d = '0;
		unique case (state_q)
			lpp_pkg::LPP_RUN: begin
				if (req_s2_q) begin
					state_d = lpp_pkg::LPP_ENTERING;
				end
			end
			lpp_pkg::LPP_ENTERING: begin
				if (!req_s2_q) begin
					state_d = lpp_pkg::LPP_RUN;
				end else if (entry_done) begin
					state_d = lpp_pkg::LPP_SLEEP;
				end else begin
					cnt_d = cnt_next;
				end
			end
			lpp_pkg::LPP_SLEEP: begin
				if (!req_s2_q) begin
					state_d = lpp_pkg::LPP_WAKING;
				end
			end
			lpp_pkg::LPP_WAKING: begin
				// New request while still off: stay off, restart exit later
				if (req_s2_q) begin
					state_d = lpp_pkg::LPP_SLEEP;
				end else if (exit_done) begin
					state_d = lpp_pkg::LPP_RUN;
				end else begin
					cnt_d = cnt_next;
				end
			end
		endcase
	end

	// State and delay counter
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_q <= lpp_pkg::LPP_RUN;
			cnt_q <= '0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	// Lock survives everything but power-up reset; never cleared by logic
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			lock_q <= 1'b0;
		end else if (probe_lock) begin
			lock_q <= 1'b1;
		end
	end

	// Awake decode of the next state, so controls change with the state
	wire run_d = is_awake(state_d);

	// Power controls follow the next state; registering the next state
	// keeps these outputs on flops and aligned with the state register
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			core_on <= 1'b1;
			io_enable <= 1'b1;
			in_buf_on <= 1'b1;
			sleeping <= 1'b0;
			probe_locked <= 1'b0;
		end else begin
			core_on <= run_d;
			io_enable <= run_d;
			in_buf_on <= run_d;
			sleeping <= (state_d == lpp_pkg::LPP_SLEEP);
			probe_locked <= lock_q | probe_lock;
		end
	end

	// Pads follow the current state, so they float one cycle after the
	// core controls drop and drive one cycle after they rise
	wire io_act = is_awake(state_q);

	// Probing is refused from the cycle the lock request is seen
	wire probe_ok = ~(lock_q | probe_lock);

	// Two independent probe pins
	lpp_probe_pin u_probe_a (
		.mclk(mclk),
		.rst_n(rst_n),
		.cfg(probe_cfg_a),
		.probe_allowed(probe_ok),
		.io_active(io_act),
		.nodes(nodes),
		.user_out(user_out[0]),
		.user_oe(user_oe[0]),
		.pad(probe_output_a)
	);

	lpp_probe_pin u_probe_b (
		.mclk(mclk),
		.rst_n(rst_n),
		.cfg(probe_cfg_b),
		.probe_allowed(probe_ok),
		.io_active(io_act),
		.nodes(nodes),
		.user_out(user_out[1]),
		.user_oe(user_oe[1]),
		.pad(probe_output_b)
	);
endmodule : lpp_sleep_ctrl

//--- tb/lpp_host.sv
// Outside controller model driving the sleep request pin
`timescale 1ns/1ps
module lpp_host (
	// Clock and command
	input wire logic mclk,
	input wire logic go,
	// Pin to the device
	output logic sleep_request_pin
);
	// Pin idles low as through its pull-down; moves after the sampling edge
	initial sleep_request_pin = 1'b0;
	always @(posedge mclk) sleep_request_pin <= go;
endmodule : lpp_host

//--- tb/lpp_sleep_ctrl_properties.sv
// Checker for the sleep sequencer and probe pins
`timescale 1ns/1ps
module lpp_sleep_ctrl_chk (
	// Clock and inputs
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic sleep_request_pin,
	input wire lpp_pkg::lpp_probe_cfg_t probe_cfg_a,
	input wire lpp_pkg::lpp_probe_cfg_t probe_cfg_b,
	input wire logic [15:0] nodes,
	// Outputs watched
	input wire logic core_on,
	input wire logic io_enable,
	input wire logic in_buf_on,
	input wire logic sleeping,
	input wire logic probe_locked,
	input wire lpp_pkg::lpp_pad_t probe_output_a,
	input wire lpp_pkg::lpp_pad_t probe_output_b
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Power state and pads
	sleep_off_a: assert property (
		sleeping |-> !core_on && !in_buf_on && !io_enable) else $error("on");
	pad_float_a: assert property (
		sleeping && $past(sleeping) |-> !probe_output_a.oe
		&& !probe_output_b.oe) else $error("pad driven");
	entry_time_a: assert property (
		$rose(sleeping) |-> $past(sleep_request_pin, 160)) else $error("early");
	partial_off_a: assert property (
		$fell(core_on) |-> sleeping && $past(sleep_request_pin, 3))
		else $error("partial");
	wake_slow_a: assert property (
		$fell(sleeping) ##0 !sleep_request_pin[*8] |-> !core_on)
		else $error("fast wake");
	// Probe pins
	probe_a_a: assert property ($stable(nodes) && $stable(probe_cfg_a)
		&& probe_cfg_a.enable && !probe_locked && core_on && $past(core_on)
		&& $past(rst_n) |-> probe_output_a == {nodes[probe_cfg_a.sel], 1'b1})
		else $error("probe a");
	probe_b_a: assert property ($stable(nodes) && $stable(probe_cfg_b)
		&& probe_cfg_b.enable && !probe_locked && core_on && $past(core_on)
		&& $past(rst_n) |-> probe_output_b == {nodes[probe_cfg_b.sel], 1'b1})
		else $error("probe b");
	lock_keep_a: assert property (
		probe_locked |=> probe_locked) else $error("unlocked");
endmodule : lpp_sleep_ctrl_chk
bind lpp_sleep_ctrl lpp_sleep_ctrl_chk lpp_sleep_ctrl_chk_i (.mclk, .rst_n,
	.sleep_request_pin, .probe_cfg_a, .probe_cfg_b, .nodes, .core_on,
	.io_enable, .in_buf_on, .sleeping, .probe_locked, .probe_output_a,
	.probe_output_b);

//--- tb/lpp_sleep_ctrl_tb_top.sv
// Testbench for the sleep sequencer and probe pins
`timescale 1ns/1ps
module lpp_sleep_ctrl_tb_top;
	logic mclk = 0, rst_n = 0, go = 0, lock = 0, pin;
	lpp_pkg::lpp_probe_cfg_t ca = '0, cb = '0;
	logic [15:0] nodes = 16'ha5c3;
	logic [1:0] uo = '0, ue = '0;
	logic core_on, io_enable, in_buf_on, sleeping, probe_locked;
	lpp_pkg::lpp_pad_t pa, pb;
	int fail_count = 0, samples_checked = 0, n;
	// Clock, partner and device
	always #2.5 mclk = ~mclk;
	lpp_host lpp_host_i (.mclk, .go, .sleep_request_pin(pin));
	lpp_sleep_ctrl lpp_sleep_ctrl_i (.mclk, .rst_n, .sleep_request_pin(pin),
		.probe_cfg_a(ca), .probe_cfg_b(cb), .probe_lock(lock), .nodes,
		.user_out(uo), .user_oe(ue), .core_on, .io_enable, .in_buf_on,
		.sleeping, .probe_locked, .probe_output_a(pa), .probe_output_b(pb));
	task finish_test;
		$display("checked %0d failed %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : finish_test
	task chk(input logic [15:0] g, e);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("Error %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	task cyc(input int k);
		repeat (k) @(negedge mclk);
	endtask : cyc
	// Count edges until sleeping or core_on reaches a level
	task wait_lvl(input logic on_core, input logic v, input int lim);
		n = 0;
		do begin
			@(posedge mclk);
			#1 n++;
			if (n > lim) begin
				fail_count++;
				finish_test();
			end
		end while ((on_core ? core_on : sleeping) !== v);
	endtask : wait_lvl
	task t_probe;
		ca = 5'h10;
		cb = 5'h1c;
		cyc(3);
		chk(pa, {nodes[0], 1'b1});
		chk(pb, {nodes[12], 1'b1});
		nodes = 16'h1000;
		cyc(3);
		chk(pb, 2'b11);
		ca = 5'h03;
		uo = 2'b01;
		ue = 2'b01;
		cyc(3);
		chk(pa, 2'b11);
		$display("probe done");
	endtask : t_probe
	task t_abort;
		go = 1;
		cyc(100);
		go = 0;
		cyc(300);
		chk({sleeping, core_on}, 2'b01);
		$display("abort done");
	endtask : t_abort
	task t_sleep;
		go = 1;
		wait_lvl(0, 1, 200);
		chk(n >= 160 && n <= 168, 1);
		cyc(50);
		chk({sleeping, core_on, io_enable, in_buf_on, pa.oe, pb.oe}, 32);
		go = 0;
		wait_lvl(1, 1, 41000);
		chk(n >= 40000 && n <= 40008, 1);
		$display("sleep done");
	endtask : t_sleep
	task t_lock;
		ca = 5'h10;
		ue = 0;
		lock = 1;
		cyc(1);
		lock = 0;
		cyc(3);
		chk({probe_locked, pa.oe}, 2'b10);
		$display("lock done");
	endtask : t_lock
	initial begin
		cyc(20);
		rst_n = 1;
		cyc(2);
		chk({core_on, sleeping, probe_locked}, 3'b100);
		t_probe();
		t_abort();
		t_sleep();
		cyc(2);
		t_lock();
		finish_test();
	end
endmodule : lpp_sleep_ctrl_tb_top
